//--- hw/maif_axis.sv
// One axis: selected cause, comparators and sticky status flags
`timescale 1ns/1ps
module maif_axis import maif_pkg::*; #(
	parameter int POS_W = 32
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [POS_W-1:0] pos_logical,
	input wire logic [POS_W-1:0] pos_real,
	input wire logic use_real,
	input wire logic [POS_W-1:0] cmp_neg,
	input wire logic [POS_W-1:0] cmp_pos,
	input wire logic const_speed_begin,
	input wire logic const_speed_end,
	input wire logic drive_done,
	input wire logic cause_wr,
	input wire logic [CODE_W-1:0] cause_code,
	input wire logic cause_off,
	input wire logic status_rd,
	output maif_cause_t cause,
	output logic [STAT_W-1:0] status,
	output logic [3:0] cond_now,
	output logic hit,
	output logic overrun
);

	maif_cause_t cause_q, cause_d;
	logic [STAT_W-1:0] status_q, status_d;
	logic cond_prev_q, cond_prev_d;
	logic [POS_W-1:0] pos;
	logic cond;
	logic hit_c;

	assign pos = use_real ? pos_real : pos_logical;
	// Live comparator outputs: ge_neg, lt_neg, ge_pos, lt_pos
	assign cond_now[0] = $signed(pos) >= $signed(cmp_neg);
	assign cond_now[1] = $signed(pos) < $signed(cmp_neg);
	assign cond_now[2] = $signed(pos) >= $signed(cmp_pos);
	assign cond_now[3] = $signed(pos) < $signed(cmp_pos);

	always_comb begin
		cond = 1'b0;
		case (cause_q)
			MAIF_GE_NEG: cond = cond_now[0];
			MAIF_LT_NEG: cond = cond_now[1];
			MAIF_GE_POS: cond = cond_now[2];
			MAIF_LT_POS: cond = cond_now[3];
			default: cond = 1'b0;
		endcase
	end

	always_comb begin
		case (cause_q)
			MAIF_CS_END: hit_c = const_speed_end;
			MAIF_CS_BEGIN: hit_c = const_speed_begin;
			MAIF_DRV_DONE: hit_c = drive_done;
			MAIF_NONE: hit_c = 1'b0;
			default: hit_c = cond & ~cond_prev_q;
		endcase
	end

	always_comb begin
		cause_d = cause_q;
		status_d = status_q;
		cond_prev_d = cond;
		if (status_rd) begin
			status_d = RST_STATUS;
		end
		if (cause_off) begin
			cause_d = MAIF_NONE;
			status_d = RST_STATUS;
		end else begin
			if (hit_c) begin
				status_d = status_q | status_mask(cause_q);
			end
			if (cause_wr) begin
				cause_d = maif_cause_t'(cause_code);
				// Re-arm so a condition already true raises at once
				cond_prev_d = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			cause_q <= MAIF_NONE;
			status_q <= RST_STATUS;
			cond_prev_q <= 1'b0;
		end else if (ce) begin
			cause_q <= cause_d;
			status_q <= status_d;
			cond_prev_q <= cond_prev_d;
		end
	end

	assign cause = cause_q;
	assign status = status_q;
	assign hit = hit_c & ~cause_off & ce;
	assign overrun = hit & ((status_q & status_mask(cause_q)) != RST_STATUS);

endmodule : maif_axis

//--- hw/maif_pkg.sv
// Shared constants and types for the per-axis motion interrupt block
package maif_pkg;

	localparam int MAX_AXES = 2;
	localparam int MAX_POS_W = 32;
	localparam int CODE_W = 3;
	localparam int STAT_W = 16;

	// Register byte offsets
	localparam logic [7:0] OFF_CAUSE_SET = 8'h00;
	localparam logic [7:0] OFF_CAUSE_OFF = 8'h04;
	localparam logic [7:0] OFF_POS_SRC = 8'h08;
	localparam logic [7:0] OFF_COND = 8'h0c;
	localparam logic [7:0] OFF_CMP_BASE = 8'h10;
	localparam logic [7:0] OFF_STAT_BASE = 8'h20;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h30;
	localparam logic [7:0] OFF_IRQ_CLR = 8'h34;
	localparam logic [7:0] OFF_IRQ_EN = 8'h38;

	// Compare block: axis a at base + 8*a, negative side then positive side
	localparam int CMP_AXIS_BIT = 3;
	localparam int CMP_SIDE_BIT = 2;
	localparam int STAT_AXIS_BIT = 2;

	// Field positions
	localparam int CAUSE_MASK_LSB = 0;
	localparam int CAUSE_CODE_LSB = 8;
	localparam int CAUSE_RD_STRIDE = 4;
	localparam int IRQ_OVR_LSB = 8;

	// Reset values
	localparam logic [STAT_W-1:0] RST_STATUS = 16'h0000;
	localparam logic [31:0] RST_CMP = 32'h0000_0000;
	localparam logic [MAX_AXES-1:0] RST_POS_SRC = 2'h0;
	localparam logic [MAX_AXES-1:0] RST_IRQ = 2'h0;

	typedef enum logic [CODE_W-1:0] {
		MAIF_NONE = 3'b000,
		MAIF_GE_NEG = 3'b001,
		MAIF_LT_NEG = 3'b010,
		MAIF_GE_POS = 3'b011,
		MAIF_LT_POS = 3'b100,
		MAIF_CS_END = 3'b101,
		MAIF_CS_BEGIN = 3'b110,
		MAIF_DRV_DONE = 3'b111
	} maif_cause_t;

	// Status bit masks of axis_interrupt_status
	localparam logic [STAT_W-1:0] ST_GE_NEG = 16'h0002;
	localparam logic [STAT_W-1:0] ST_LT_NEG = 16'h0004;
	localparam logic [STAT_W-1:0] ST_LT_POS = 16'h0008;
	localparam logic [STAT_W-1:0] ST_GE_POS = 16'h0010;
	localparam logic [STAT_W-1:0] ST_CS_END = 16'h0020;
	localparam logic [STAT_W-1:0] ST_CS_BEGIN = 16'h0040;
	localparam logic [STAT_W-1:0] ST_DRV_DONE = 16'h0080;

	function automatic logic [STAT_W-1:0] status_mask(maif_cause_t c);
		logic [STAT_W-1:0] m;
		m = RST_STATUS;
		case (c)
			MAIF_GE_NEG: m = ST_GE_NEG;
			MAIF_LT_NEG: m = ST_LT_NEG;
			MAIF_GE_POS: m = ST_GE_POS;
			MAIF_LT_POS: m = ST_LT_POS;
			MAIF_CS_END: m = ST_CS_END;
			MAIF_CS_BEGIN: m = ST_CS_BEGIN;
			MAIF_DRV_DONE: m = ST_DRV_DONE;
			default: m = RST_STATUS;
		endcase
		return m;
	endfunction : status_mask

	function automatic logic [31:0] apply_strb(logic [31:0] old,
		logic [31:0] wdata, logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = wdata[i*8 +: 8];
			end
		end
		return r;
	endfunction : apply_strb

endpackage : maif_pkg

//--- hw/maif_top.sv
// Per-axis interrupt cause selection with APB register access
// Summary of operation
// - Written cause code arms interrupt for axes
// - Code 1: position at/above negative compare
// - Code 2: position below negative compare
// - Codes 3/4: at/above, below positive compare
// - Code 5: constant-speed or offset output ends
// - Code 6: constant-speed or offset output begins
// - Code 7: pulse driving has finished
// - Disable write clears selected axes' causes
// - Status bits 0x002..0x010 flag comparisons
// - Status bits 0x020/0x040/0x080 flag motion events
`timescale 1ns/1ps
module maif_top import maif_pkg::*; #(
	parameter int NUM_AXES = 2,
	parameter int POS_W = 32
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_AXES-1:0][POS_W-1:0] pos_logical,
	input wire logic [NUM_AXES-1:0][POS_W-1:0] pos_real,
	input wire logic [NUM_AXES-1:0] const_speed_begin,
	input wire logic [NUM_AXES-1:0] const_speed_end,
	input wire logic [NUM_AXES-1:0] drive_done,
	output logic irq
);

	if (NUM_AXES < 1 || NUM_AXES > MAX_AXES) begin : g_bad_axes
		$error("NUM_AXES must be 1 or 2");
	end
	if (POS_W < 2 || POS_W > MAX_POS_W) begin : g_bad_pos_w
		$error("POS_W must be 2 to 32");
	end

	// Bus slave state
	logic acc_q, acc_d;
	logic [31:0] prdata_q, prdata_d;
	logic err_q, err_d;

	// Software-visible configuration and interrupt state
	logic [NUM_AXES-1:0][POS_W-1:0] cmp_neg_q, cmp_neg_d;
	logic [NUM_AXES-1:0][POS_W-1:0] cmp_pos_q, cmp_pos_d;
	logic [NUM_AXES-1:0] pos_src_q, pos_src_d;
	logic [NUM_AXES-1:0] irq_ev_q, irq_ev_d;
	logic [NUM_AXES-1:0] irq_ovr_q, irq_ovr_d;
	logic [NUM_AXES-1:0] irq_en_q, irq_en_d;

	// Per-axis connections
	maif_cause_t [NUM_AXES-1:0] cause;
	logic [NUM_AXES-1:0][STAT_W-1:0] status;
	logic [NUM_AXES-1:0][3:0] cond_now;
	logic [NUM_AXES-1:0] hit;
	logic [NUM_AXES-1:0] overrun;
	logic [NUM_AXES-1:0] cause_wr;
	logic [NUM_AXES-1:0] cause_off;
	logic [NUM_AXES-1:0] status_rd;

	// Transfer phases
	logic setup;
	logic wr_fire;
	logic rd_fire;
	logic cmp_area;
	logic stat_area;
	logic [0:0] cmp_axis;
	logic [0:0] stat_axis;
	logic cmp_side;

	assign setup = psel & ~penable & ce;
	assign pready = ce & acc_q;
	assign wr_fire = psel & penable & pready & pwrite;
	assign rd_fire = psel & penable & pready & ~pwrite;
	assign prdata = prdata_q;
	assign pslverr = pready & err_q;

	assign cmp_area = paddr[7:4] == OFF_CMP_BASE[7:4];
	assign stat_area = (paddr[7:4] == OFF_STAT_BASE[7:4]) &
		~paddr[CMP_AXIS_BIT];
	assign cmp_axis = paddr[CMP_AXIS_BIT];
	assign stat_axis = paddr[STAT_AXIS_BIT];
	assign cmp_side = paddr[CMP_SIDE_BIT];

	// Read data and error are captured in the setup cycle
	always_comb begin
		prdata_d = prdata_q;
		err_d = err_q;
		acc_d = acc_q;
		if (setup) begin
			acc_d = 1'b1;
			prdata_d = 32'h0000_0000;
			err_d = 1'b0;
			if (paddr[1:0] != 2'h0) begin
				err_d = 1'b1;
			end else if (paddr == OFF_CAUSE_SET) begin
				for (int a = 0; a < NUM_AXES; a++) begin
					prdata_d[a*CAUSE_RD_STRIDE +: CODE_W] = cause[a];
				end
			end else if (paddr == OFF_CAUSE_OFF) begin
				prdata_d = 32'h0000_0000;
			end else if (paddr == OFF_POS_SRC) begin
				prdata_d[NUM_AXES-1:0] = pos_src_q;
			end else if (paddr == OFF_COND) begin
				for (int a = 0; a < NUM_AXES; a++) begin
					prdata_d[a*4 +: 4] = cond_now[a];
				end
			end else if (cmp_area && int'(cmp_axis) < NUM_AXES) begin
				prdata_d[POS_W-1:0] = cmp_side ?
					cmp_pos_q[cmp_axis] : cmp_neg_q[cmp_axis];
			end else if (stat_area && int'(stat_axis) < NUM_AXES) begin
				prdata_d[STAT_W-1:0] = status[stat_axis];
			end else if (paddr == OFF_IRQ_STAT) begin
				prdata_d[NUM_AXES-1:0] = irq_ev_q;
				prdata_d[IRQ_OVR_LSB +: NUM_AXES] = irq_ovr_q;
			end else if (paddr == OFF_IRQ_CLR) begin
				prdata_d = 32'h0000_0000;
			end else if (paddr == OFF_IRQ_EN) begin
				prdata_d[NUM_AXES-1:0] = irq_en_q;
			end else begin
				err_d = 1'b1;
			end
		end else if (pready) begin
			acc_d = 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			acc_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
			err_q <= 1'b0;
		end else if (ce) begin
			acc_q <= acc_d;
			prdata_q <= prdata_d;
			err_q <= err_d;
		end
	end

	// Command strobes towards the axes; erroring accesses have no effect
	always_comb begin
		cause_wr = '0;
		cause_off = '0;
		status_rd = '0;
		for (int a = 0; a < NUM_AXES; a++) begin
			if (wr_fire && !err_q && paddr == OFF_CAUSE_SET &&
				pstrb[1:0] == 2'h3) begin
				cause_wr[a] = pwdata[CAUSE_MASK_LSB + a];
			end
			if (wr_fire && !err_q && paddr == OFF_CAUSE_OFF && pstrb[0]) begin
				cause_off[a] = pwdata[CAUSE_MASK_LSB + a];
			end
			if (rd_fire && !err_q && stat_area && int'(stat_axis) == a) begin
				status_rd[a] = 1'b1;
			end
		end
	end

	// Compare values and position source; loaded by the host beforehand
	always_comb begin
		logic [31:0] w;
		w = 32'h0000_0000;
		cmp_neg_d = cmp_neg_q;
		cmp_pos_d = cmp_pos_q;
		pos_src_d = pos_src_q;
		if (wr_fire && !err_q) begin
			if (cmp_area && int'(cmp_axis) < NUM_AXES) begin
				if (cmp_side) begin
					w = apply_strb(32'(cmp_pos_q[cmp_axis]), pwdata, pstrb);
					cmp_pos_d[cmp_axis] = w[POS_W-1:0];
				end else begin
					w = apply_strb(32'(cmp_neg_q[cmp_axis]), pwdata, pstrb);
					cmp_neg_d[cmp_axis] = w[POS_W-1:0];
				end
			end else if (paddr == OFF_POS_SRC) begin
				w = apply_strb(32'(pos_src_q), pwdata, pstrb);
				pos_src_d = w[NUM_AXES-1:0];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			for (int a = 0; a < NUM_AXES; a++) begin
				cmp_neg_q[a] <= RST_CMP[POS_W-1:0];
				cmp_pos_q[a] <= RST_CMP[POS_W-1:0];
			end
			pos_src_q <= RST_POS_SRC[NUM_AXES-1:0];
		end else if (ce) begin
			cmp_neg_q <= cmp_neg_d;
			cmp_pos_q <= cmp_pos_d;
			pos_src_q <= pos_src_d;
		end
	end

	// Sticky event and overrun bits; a new event wins over a clear
	always_comb begin
		logic [31:0] w;
		w = 32'h0000_0000;
		irq_ev_d = irq_ev_q;
		irq_ovr_d = irq_ovr_q;
		irq_en_d = irq_en_q;
		if (wr_fire && !err_q && paddr == OFF_IRQ_CLR) begin
			if (pstrb[0]) begin
				irq_ev_d = irq_ev_q & ~pwdata[NUM_AXES-1:0];
			end
			if (pstrb[1]) begin
				irq_ovr_d = irq_ovr_q & ~pwdata[IRQ_OVR_LSB +: NUM_AXES];
			end
		end
		if (wr_fire && !err_q && paddr == OFF_IRQ_EN) begin
			w = apply_strb(32'(irq_en_q), pwdata, pstrb);
			irq_en_d = w[NUM_AXES-1:0];
		end
		// Disabling an axis drops its pending interrupt as well
		irq_ev_d = irq_ev_d & ~cause_off;
		irq_ev_d = irq_ev_d | hit;
		irq_ovr_d = irq_ovr_d | overrun;
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			irq_ev_q <= RST_IRQ[NUM_AXES-1:0];
			irq_ovr_q <= RST_IRQ[NUM_AXES-1:0];
			irq_en_q <= RST_IRQ[NUM_AXES-1:0];
		end else if (ce) begin
			irq_ev_q <= irq_ev_d;
			irq_ovr_q <= irq_ovr_d;
			irq_en_q <= irq_en_d;
		end
	end

	assign irq = |(irq_ev_q & irq_en_q);

	for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
		maif_axis #(
			.POS_W(POS_W)
		) u_axis (
			.clk_sys(clk_sys),
			.reset(reset),
			.ce(ce),
			.pos_logical(pos_logical[a]),
			.pos_real(pos_real[a]),
			.use_real(pos_src_q[a]),
			.cmp_neg(cmp_neg_q[a]),
			.cmp_pos(cmp_pos_q[a]),
			.const_speed_begin(const_speed_begin[a]),
			.const_speed_end(const_speed_end[a]),
			.drive_done(drive_done[a]),
			.cause_wr(cause_wr[a]),
			.cause_code(pwdata[CAUSE_CODE_LSB +: CODE_W]),
			.cause_off(cause_off[a]),
			.status_rd(status_rd[a]),
			.cause(cause[a]),
			.status(status[a]),
			.cond_now(cond_now[a]),
			.hit(hit[a]),
			.overrun(overrun[a])
		);
	end

endmodule : maif_top

//--- tb/maif_top_asserts.sv
// Port-level checks of the motion interrupt block
`timescale 1ns/1ps
module maif_top_asserts import maif_pkg::*; #(
	parameter int NUM_AXES = 2,
	parameter int POS_W = 32
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic irq
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);
	wire logic rd_ok;
	wire logic off_all;
	assign rd_ok = pready && !pwrite && !pslverr;
	assign off_all = psel && penable && pready && pwrite && pstrb[0]
		&& paddr == OFF_CAUSE_OFF && pwdata[1:0] == 2'b11;
	a_ready_access: assert property (psel && penable && ce |-> pready)
		else $error("no pready in access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error response");
	a_misalign_err: assert property (pready && paddr[1:0] != 2'b00
		|-> pslverr) else $error("misaligned access not refused");
	a_stat_bits: assert property (rd_ok
		&& paddr[7:3] == 5'h04 |-> (prdata & ~32'h0fe) == 32'h0)
		else $error("stray status bit");
	a_irq_shown: assert property (rd_ok && paddr == OFF_IRQ_STAT
		&& $past(irq) |-> prdata[1:0] != 2'b00)
		else $error("irq without event flag");
	a_disable_quiet: assert property (off_all |=> !irq [*2])
		else $error("irq after disable");
	a_cause_read: assert property (rd_ok && paddr == OFF_CAUSE_SET
		|-> (prdata & ~32'h77) == 32'h0) else $error("cause read bad");
	a_off_zero: assert property (rd_ok && paddr == OFF_CAUSE_OFF
		|-> prdata == 32'h0) else $error("disable reads nonzero");
	c_irq: cover property ($rose(irq));
	c_err: cover property (pslverr);
	c_off: cover property (off_all);
endmodule : maif_top_asserts

bind maif_top maif_top_asserts #(.NUM_AXES(NUM_AXES), .POS_W(POS_W)) i_chk (
	.clk_sys(clk_sys), .reset(reset), .ce(ce), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

//--- tb/maif_top_tb.sv
// Register-level test of the motion interrupt block
`timescale 1ns/1ps
module maif_top_tb import maif_pkg::*;;
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic ce = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rdat;
	logic pready;
	logic pslverr;
	logic irq;
	logic err;
	logic [1:0][31:0] pl = '0;
	logic [1:0][31:0] pr = '0;
	logic [1:0] csb = 2'h0;
	logic [1:0] cse = 2'h0;
	logic [1:0] dd = 2'h0;
	int n_errors = 0;
	int n_checks = 0;

	maif_top #(.NUM_AXES(2), .POS_W(32)) i_dut (.clk_sys(clk_sys),
		.reset(reset), .ce(ce), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.pstrb(4'hf), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pos_logical(pl), .pos_real(pr),
		.const_speed_begin(csb), .const_speed_end(cse),
		.drive_done(dd), .irq(irq));

	always #12.5 clk_sys = ~clk_sys;

	task automatic chk(input string s, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : chk

	task automatic chk_irq(input logic e);
		@(negedge clk_sys);
		chk("irq", {31'h0, e}, {31'h0, irq});
	endtask : chk_irq

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string s);
		apb(1'b0, a, 32'h0);
		chk(s, e, rdat);
	endtask : rd

	// Codes 5, 6 and 7 pick the event line to pulse
	task automatic pulse(input int k, input int ax);
		@(posedge clk_sys);
		cse[ax] <= (k == 5);
		csb[ax] <= (k == 6);
		dd[ax] <= (k == 7);
		@(posedge clk_sys);
		cse <= 2'h0;
		csb <= 2'h0;
		dd <= 2'h0;
	endtask : pulse

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		#100000;
		n_errors++;
		tally_and_finish;
	end

	initial begin
		logic [15:0] m [1:7];
		logic [31:0] b;
		logic [31:0] f;
		logic [31:0] t;
		m = '{ST_GE_NEG, ST_LT_NEG, ST_GE_POS, ST_LT_POS, ST_CS_END,
			ST_CS_BEGIN, ST_DRV_DONE};
		repeat (4) @(posedge clk_sys);
		reset <= 1'b0;
		rd(OFF_STAT_BASE, 32'h0, "stat_reset");
		rd(OFF_CAUSE_SET, 32'h0, "cause_reset");
		apb(1'b1, OFF_STAT_BASE, 32'hff);
		rd(OFF_STAT_BASE, 32'h0, "stat_ro");
		rd(8'h40, 32'h0, "unmapped");
		chk("unmapped_err", 32'h1, {31'h0, err});
		rd(OFF_STAT_BASE + 8'h02, 32'h0, "misaligned");
		chk("misaligned_err", 32'h1, {31'h0, err});
		chk_irq(1'b0);
		$display("test reset done");
		apb(1'b1, OFF_IRQ_EN, 32'h3);
		for (int k = 5; k < 8; k++) begin
			apb(1'b1, OFF_CAUSE_SET, {21'h0, k[2:0], 8'h01});
			rd(OFF_CAUSE_SET, {29'h0, k[2:0]}, "cause_x");
			pulse(k == 7 ? 5 : k + 1, 0);
			pulse(k, 1);
			chk_irq(1'b0);
			pulse(k, 0);
			chk_irq(1'b1);
			rd(OFF_STAT_BASE, {16'h0, m[k]}, "stat_ev");
			rd(OFF_STAT_BASE, 32'h0, "stat_clr");
			chk_irq(1'b1);
			apb(1'b1, OFF_IRQ_CLR, 32'h3);
			chk_irq(1'b0);
		end
		$display("test events done");
		apb(1'b1, OFF_CMP_BASE, 32'd100);
		apb(1'b1, OFF_CMP_BASE + 8'h04, 32'd200);
		for (int k = 1; k < 5; k++) begin
			b = (k < 3) ? 32'd100 : 32'd200;
			f = k[0] ? b - 32'd1 : b;
			t = k[0] ? b : b - 32'd1;
			apb(1'b1, OFF_POS_SRC, {31'h0, k[1]});
			pl[0] <= k[1] ? t : f;
			pr[0] <= k[1] ? f : t;
			apb(1'b1, OFF_CAUSE_SET, {21'h0, k[2:0], 8'h01});
			repeat (3) @(posedge clk_sys);
			rd(OFF_STAT_BASE, 32'h0, "cmp_idle");
			pl[0] <= t;
			pr[0] <= t;
			repeat (3) @(posedge clk_sys);
			rd(OFF_STAT_BASE, {16'h0, m[k]}, "cmp_hit");
			chk_irq(1'b1);
			apb(1'b1, OFF_CAUSE_OFF, 32'h3);
		end
		$display("test compare done");
		apb(1'b1, OFF_CAUSE_SET, 32'h0000_0703);
		rd(OFF_CAUSE_SET, 32'h77, "cause_xy");
		pulse(7, 0);
		pulse(7, 1);
		chk_irq(1'b1);
		rd(OFF_IRQ_STAT, 32'h3, "irq_stat");
		apb(1'b1, OFF_CAUSE_OFF, 32'h3);
		chk_irq(1'b0);
		pulse(7, 0);
		pulse(7, 1);
		chk_irq(1'b0);
		rd(OFF_STAT_BASE + 8'h04, 32'h0, "stat_y");
		rd(OFF_CAUSE_SET, 32'h0, "cause_off");
		$display("test disable done");
		apb(1'b1, OFF_IRQ_EN, 32'h0);
		apb(1'b1, OFF_CAUSE_SET, 32'h0000_0601);
		pulse(6, 0);
		chk_irq(1'b0);
		rd(OFF_IRQ_STAT, 32'h1, "irq_masked");
		// A second event while the status flag still stands is an overrun
		pulse(6, 0);
		rd(OFF_IRQ_STAT, 32'h101, "irq_overrun");
		apb(1'b1, OFF_IRQ_EN, 32'h1);
		chk_irq(1'b1);
		apb(1'b1, OFF_IRQ_CLR, 32'h1);
		chk_irq(1'b0);
		$display("test mask done");
		// An event while the clock enable is low must not be taken
		@(posedge clk_sys);
		ce <= 1'b0;
		pulse(6, 0);
		@(posedge clk_sys);
		ce <= 1'b1;
		chk_irq(1'b0);
		pulse(6, 0);
		chk_irq(1'b1);
		$display("test freeze done");
		tally_and_finish;
	end
endmodule : maif_top_tb
